/* File: include/aad_pkg.sv */
// Purpose: shared constants and types of the motion event detector
// Assumes: 200 MHz clock, 16-bit register port, 12-bit signed samples
// Notes: all timing counts derive from microsecond figures and clock rate
package aad_pkg;
  localparam int CLK_MHZ = 200;
  // timer periods in microseconds, slow for odr up to 3200 Hz, fast for 6400 Hz
  localparam int ACT_SLOW_US = 6600;
  localparam int ACT_FAST_US = 3300;
  localparam int INACT_SLOW_US = 26000;
  localparam int INACT_FAST_US = 13000;
  localparam int ACT_SLOW_CYC = ACT_SLOW_US * CLK_MHZ;
  localparam int ACT_FAST_CYC = ACT_FAST_US * CLK_MHZ;
  localparam int INACT_SLOW_CYC = INACT_SLOW_US * CLK_MHZ;
  localparam int INACT_FAST_CYC = INACT_FAST_US * CLK_MHZ;
  localparam int TMR_W = 24;

  localparam int SW = 12;
  localparam int TW = 11;
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int ACT_TIME_W = 8;
  localparam int INACT_TIME_W = 16;
  // corner of the smoothing filter is set by this shift and the sample rate
  localparam int LPF_SHIFT = 3;

  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_AXIS_ENABLE = 4'h1;
  localparam logic [AW-1:0] REG_X_AXIS_MOTION_THRESHOLD = 4'h2;
  localparam logic [AW-1:0] REG_X_AXIS_STILL_THRESHOLD = 4'h5;
  localparam logic [AW-1:0] REG_ACT_TIME = 4'h8;
  localparam logic [AW-1:0] REG_INACT_TIME = 4'h9;
  localparam logic [AW-1:0] REG_SECONDARY_EVENT_STATUS = 4'ha;

  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_MEAS = 2'h2;
  localparam logic [1:0] LINK_DEFAULT = 2'h0;
  localparam logic [1:0] LINK_LINKED = 2'h1;
  localparam logic [1:0] LINK_LOOP = 2'h3;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_WAKE = 3'b010,
    ST_MEAS = 3'b100
  } aadState_e;

  typedef struct packed {
    logic [4:0] spare;
    logic inactIe;
    logic actIe;
    logic autoSleep;
    logic [1:0] link;
    logic lpfOn;
    logic inactivityReferenceSelect;
    logic activityReferenceSelect;
    logic odrFast;
    logic [1:0] mode;
  } aadCtrl_s;

  typedef struct packed {
    logic [10:0] spare;
    logic [1:0] mode;
    logic awake;
    logic inactEvent;
    logic actEvent;
  } aadStatus_s;

  typedef struct packed {
    logic [2:0][SW-1:0] axis;
  } aadAccel_s;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic we;
    logic re;
  } aadBusReq_s;

  localparam aadCtrl_s CTRL_RESET = 16'h0000;
  localparam logic [5:0] AXES_RESET = 6'h00;
  localparam logic [TW-1:0] THR_RESET = 11'h000;
  localparam logic [ACT_TIME_W-1:0] ACT_TIME_RESET = 8'h00;
  localparam logic [INACT_TIME_W-1:0] INACT_TIME_RESET = 16'h0000;
endpackage

/* File: logic/aad_activity_detector.sv */
// Purpose: activity and inactivity detection with timers, linking and autosleep
// Assumes: samples and bus come from logic on clk, one sample per sampleValid
// Notes: status event bits clear on read, a new event in that cycle wins
// Contract
// - any enabled axis over threshold long enough
// - per-axis activity thresholds, one shared timer
// - all enabled axes under threshold long enough
// - per-axis inactivity thresholds, one shared timer
// - reference select bits, default absolute
// - referenced activity: deviation above threshold
// - referenced inactivity: deviation below threshold
// - capture reference on measurement entry; code captures only on the first entry after both selects were absolute
// - activity period 6.6 ms, 3.3 ms fast
// - activity periods count, zero means single sample
// - activity timer runs in measurement only
// - inactivity period 26 ms, 13 ms fast
// - inactivity periods count, zero means single sample
// - wake mode single sample, then measurement
// - wake activity flags only with zero time
// - awake follows mode or activity by config
// - no interrupts while in wake mode
// - events recorded in status, optional interrupt
// - switchable smoothing filter on detection path
// - linked mode alternates the two detectors
// - autosleep loops between wake and measurement
`timescale 1ns/10ps
module aad_activity_detector
  import aad_pkg::*;
#(
  parameter logic [TMR_W-1:0] ACT_SLOW_CYC_P = TMR_W'(ACT_SLOW_CYC),
  parameter logic [TMR_W-1:0] ACT_FAST_CYC_P = TMR_W'(ACT_FAST_CYC),
  parameter logic [TMR_W-1:0] INACT_SLOW_CYC_P = TMR_W'(INACT_SLOW_CYC),
  parameter logic [TMR_W-1:0] INACT_FAST_CYC_P = TMR_W'(INACT_FAST_CYC)
) (
  input logic clk,
  input logic rst_n,
  input aadBusReq_s bus,
  output logic [DW-1:0] rdata,
  input logic sampleValid,
  input aadAccel_s sample,
  output logic actIrq,
  output logic inactIrq,
  output logic awake,
  output aadState_e state
);

  logic [1:0] rstSync;
  logic rstN;
  aadCtrl_s ctrl;
  aadCtrl_s wrCtrl;
  logic [2:0] actAxisEn;
  logic [2:0] inactAxisEn;
  logic [ACT_TIME_W-1:0] actTime;
  logic [INACT_TIME_W-1:0] inactTime;
  logic [TW-1:0] thrAct [3];
  logic [TW-1:0] thrInact [3];
  logic [SW-1:0] filt [3];
  logic [SW-1:0] refv [3];
  logic [SW-1:0] path [3];
  logic [2:0] overAct;
  logic [2:0] underInact;
  logic autoSlp;
  logic expectInact;
  logic actFlag;
  logic inactFlag;
  logic refPend;
  logic refLocked;
  logic prevMeas;
  logic refCap;
  logic actRun;
  logic inactRun;
  logic [ACT_TIME_W-1:0] actCnt;
  logic [INACT_TIME_W-1:0] inactCnt;
  logic [TMR_W-1:0] actDiv;
  logic [TMR_W-1:0] inactDiv;
  logic [TMR_W-1:0] actPeriod;
  logic [TMR_W-1:0] inactPeriod;
  logic actTick;
  logic inactTick;
  logic actQual;
  logic inactQual;
  logic actDetEn;
  logic inactDetEn;
  logic actEvt;
  logic inactEvt;
  logic actClr;
  logic linkOn;
  logic linkedOnly;
  logic ctrlWr;
  logic statRd;
  logic [1:0] modeCode;
  aadStatus_s statView;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  function automatic logic [SW:0] absDev(input logic [SW-1:0] a, input logic [SW-1:0] b,
                                         input logic useRef);
    logic signed [SW:0] d;
    d = $signed({a[SW-1], a}) - (useRef ? $signed({b[SW-1], b}) : $signed(13'h0000));
    return d[SW] ? -d : d;
  endfunction

  assign wrCtrl = aadCtrl_s'(bus.wdata);
  assign ctrlWr = bus.we && bus.addr == REG_CTRL;
  assign statRd = bus.re && bus.addr == REG_SECONDARY_EVENT_STATUS;

  // configuration; software is expected to change it only in standby
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl <= CTRL_RESET;
      {inactAxisEn, actAxisEn} <= AXES_RESET;
      actTime <= ACT_TIME_RESET;
      inactTime <= INACT_TIME_RESET;
    end else if (bus.we) begin
      case (bus.addr)
        REG_CTRL: ctrl <= wrCtrl;
        REG_AXIS_ENABLE: {inactAxisEn, actAxisEn} <= bus.wdata[5:0];
        REG_ACT_TIME: actTime <= bus.wdata[ACT_TIME_W-1:0];
        REG_INACT_TIME: inactTime <= bus.wdata;
        default: ;
      endcase
    end
  end

  for (genvar i = 0; i < 3; i++) begin : gAxis
    logic signed [SW:0] step;
    logic [SW-1:0] filtNext;
    logic [SW:0] actMag;
    logic [SW:0] inactMag;

    // first-order smoothing, one step per sample
    assign step = ($signed({sample.axis[i][SW-1], sample.axis[i]})
                   - $signed({filt[i][SW-1], filt[i]})) >>> LPF_SHIFT;
    assign filtNext = filt[i] + step[SW-1:0];
    assign path[i] = ctrl.lpfOn ? filtNext : sample.axis[i];
    assign actMag = absDev(path[i], refv[i], ctrl.activityReferenceSelect);
    assign inactMag = absDev(path[i], refv[i], ctrl.inactivityReferenceSelect);
    assign overAct[i] = actMag > {2'h0, thrAct[i]};
    assign underInact[i] = inactMag < {2'h0, thrInact[i]};

    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        thrAct[i] <= THR_RESET;
        thrInact[i] <= THR_RESET;
      end else if (bus.we) begin
        if (bus.addr == REG_X_AXIS_MOTION_THRESHOLD + AW'(i)) begin
          thrAct[i] <= bus.wdata[TW-1:0];
        end
        if (bus.addr == REG_X_AXIS_STILL_THRESHOLD + AW'(i)) begin
          thrInact[i] <= bus.wdata[TW-1:0];
        end
      end
    end

    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        filt[i] <= 12'h000;
        refv[i] <= 12'h000;
      end else begin
        // a mode write restarts smoothing so old history cannot trip a new session
        if (ctrlWr) begin
          filt[i] <= 12'h000;
        end else if (sampleValid) begin
          filt[i] <= filtNext;
        end
        if (refCap) begin
          refv[i] <= path[i];
        end
      end
    end
  end

  assign actQual = |(overAct & actAxisEn);
  assign inactQual = (|inactAxisEn) && (&(underInact | ~inactAxisEn));

  // loop behaviour is forced while autosleep runs
  assign linkOn = ctrl.link != LINK_DEFAULT || autoSlp;
  assign linkedOnly = ctrl.link == LINK_LINKED && !autoSlp;
  // in linked mode the next detector waits until the last event is read
  assign actDetEn = !linkOn || (!expectInact && !(linkedOnly && inactFlag));
  assign inactDetEn = !linkOn || (expectInact && !(linkedOnly && actFlag));

  assign actEvt = sampleValid && actDetEn && actQual
                  && (state == ST_WAKE
                      || (state == ST_MEAS && actCnt >= actTime));
  assign inactEvt = sampleValid && inactDetEn && inactQual && state != ST_STANDBY
                    && inactCnt >= inactTime;

  assign actPeriod = ctrl.odrFast ? ACT_FAST_CYC_P : ACT_SLOW_CYC_P;
  assign inactPeriod = ctrl.odrFast ? INACT_FAST_CYC_P : INACT_SLOW_CYC_P;
  assign actTick = actRun && state == ST_MEAS && actDiv == actPeriod - TMR_W'(1);
  assign inactTick = inactRun && state != ST_STANDBY
                     && inactDiv == inactPeriod - TMR_W'(1);
  // leaving or rewriting measurement drops a half-counted run
  assign actClr = state == ST_MEAS && (ctrlWr || (inactEvt && autoSlp));

  // period dividers only run during an unbroken qualifying run
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      actDiv <= '0;
    end else if (state != ST_MEAS) begin
      actDiv <= actDiv;
    end else if (!actRun || actTick || actClr) begin
      actDiv <= '0;
    end else begin
      actDiv <= actDiv + TMR_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inactDiv <= '0;
    end else if (!inactRun || inactTick || state == ST_STANDBY || ctrlWr) begin
      inactDiv <= '0;
    end else begin
      inactDiv <= inactDiv + TMR_W'(1);
    end
  end

  // period counters saturate instead of wrapping to avoid false events
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      actRun <= 1'b0;
      actCnt <= '0;
    end else if (actClr) begin
      actRun <= 1'b0;
      actCnt <= '0;
    end else if (sampleValid && state == ST_MEAS) begin
      actRun <= actQual;
      if (!actQual || actEvt) begin
        actCnt <= '0;
      end else if (actTick && actCnt != '1) begin
        actCnt <= actCnt + 1'b1;
      end
    end else if (actTick && actCnt != '1) begin
      actCnt <= actCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inactRun <= 1'b0;
      inactCnt <= '0;
    end else if (ctrlWr) begin
      inactRun <= 1'b0;
      inactCnt <= '0;
    end else if (sampleValid && state != ST_STANDBY) begin
      inactRun <= inactQual;
      if (!inactQual || inactEvt) begin
        inactCnt <= '0;
      end else if (inactTick && inactCnt != '1) begin
        inactCnt <= inactCnt + 1'b1;
      end
    end else if (inactTick && inactCnt != '1) begin
      inactCnt <= inactCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state <= ST_STANDBY;
      autoSlp <= 1'b0;
    end else if (ctrlWr) begin
      case (wrCtrl.mode)
        MODE_STANDBY: state <= ST_STANDBY;
        MODE_WAKE: state <= ST_WAKE;
        default: state <= ST_MEAS;
      endcase
      // only a manual entry into wake starts autosleep
      autoSlp <= wrCtrl.mode == MODE_WAKE && wrCtrl.autoSleep;
    end else begin
      case (state)
        ST_WAKE: if (actEvt) state <= ST_MEAS;
        ST_MEAS: if (inactEvt && autoSlp) state <= ST_WAKE;
        ST_STANDBY: state <= ST_STANDBY;
        default: state <= ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      expectInact <= 1'b0;
    end else if (ctrlWr) begin
      expectInact <= 1'b0;
    end else if (linkOn && actEvt) begin
      expectInact <= 1'b1;
    end else if (linkOn && inactEvt) begin
      expectInact <= 1'b0;
    end
  end

  // set wins over the clear-on-read
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      actFlag <= 1'b0;
      inactFlag <= 1'b0;
    end else begin
      if (actEvt && (state == ST_MEAS || actTime == '0)) begin
        actFlag <= 1'b1;
      end else if (statRd) begin
        actFlag <= 1'b0;
      end
      if (inactEvt) begin
        inactFlag <= 1'b1;
      end else if (statRd) begin
        inactFlag <= 1'b0;
      end
    end
  end

  // reference is locked until both selects return to absolute
  assign refCap = refPend && sampleValid && state == ST_MEAS;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prevMeas <= 1'b0;
      refPend <= 1'b0;
      refLocked <= 1'b0;
    end else begin
      prevMeas <= state == ST_MEAS;
      if (refCap) begin
        refPend <= 1'b0;
      end else if (state == ST_MEAS && !prevMeas && !refLocked
                   && (ctrl.activityReferenceSelect || ctrl.inactivityReferenceSelect)) begin
        refPend <= 1'b1;
      end
      if (!ctrl.activityReferenceSelect && !ctrl.inactivityReferenceSelect) begin
        refLocked <= 1'b0;
      end else if (refCap) begin
        refLocked <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awake <= 1'b0;
      actIrq <= 1'b0;
      inactIrq <= 1'b0;
    end else begin
      awake <= (ctrl.link == LINK_DEFAULT || ctrl.autoSleep) ? state == ST_MEAS
               : expectInact;
      actIrq <= actFlag && ctrl.actIe && state == ST_MEAS;
      inactIrq <= inactFlag && ctrl.inactIe && state == ST_MEAS;
    end
  end

  always_comb begin
    case (state)
      ST_WAKE: modeCode = MODE_WAKE;
      ST_MEAS: modeCode = MODE_MEAS;
      default: modeCode = MODE_STANDBY;
    endcase
  end

  always_comb begin
    statView = '0;
    statView.mode = modeCode;
    statView.awake = awake;
    statView.inactEvent = inactFlag;
    statView.actEvent = actFlag;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdata <= '0;
    end else if (bus.re) begin
      case (bus.addr)
        REG_CTRL: rdata <= {ctrl[DW-1:2], modeCode};
        REG_AXIS_ENABLE: rdata <= DW'({inactAxisEn, actAxisEn});
        4'h2: rdata <= DW'(thrAct[0]);
        4'h3: rdata <= DW'(thrAct[1]);
        4'h4: rdata <= DW'(thrAct[2]);
        4'h5: rdata <= DW'(thrInact[0]);
        4'h6: rdata <= DW'(thrInact[1]);
        4'h7: rdata <= DW'(thrInact[2]);
        REG_ACT_TIME: rdata <= DW'(actTime);
        REG_INACT_TIME: rdata <= inactTime;
        REG_SECONDARY_EVENT_STATUS: rdata <= statView;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  actZero_a:
    assert property (@(posedge clk) disable iff (!rstN)
      state == ST_MEAS && sampleValid && actDetEn && actQual && actTime == '0
      |=> actFlag)
    else $error("single-sample activity not flagged");

  wakeExit_a:
    assert property (@(posedge clk) disable iff (!rstN)
      state == ST_WAKE && actEvt && !ctrlWr |=> state == ST_MEAS)
    else $error("wake activity did not enter measurement");

  wakeNoIrq_a:
    assert property (@(posedge clk) disable iff (!rstN)
      state != ST_MEAS |=> !actIrq && !inactIrq)
    else $error("interrupt outside measurement");

  timerHold_a:
    assert property (@(posedge clk) disable iff (!rstN)
      state != ST_MEAS |=> $stable(actCnt) && $stable(actDiv))
    else $error("activity timer moved outside measurement");

  runRestart_a:
    assert property (@(posedge clk) disable iff (!rstN)
      sampleValid && state == ST_MEAS && !actQual |=> actCnt == '0 && !actRun)
    else $error("activity run not restarted");

  inactAll_a:
    assert property (@(posedge clk) disable iff (!rstN)
      $rose(inactFlag) |-> $past(sampleValid) && $past(inactQual)
      && $past(inactCnt) >= $past(inactTime))
    else $error("inactivity flagged without all axes still");

  refLock_a:
    assert property (@(posedge clk) disable iff (!rstN)
      refCap && !ctrlWr |=> refLocked && !refPend)
    else $error("reference not captured");

  awakeMode_a:
    assert property (@(posedge clk) disable iff (!rstN)
      ctrl.link == LINK_DEFAULT && state == ST_MEAS |=> awake)
    else $error("awake low in measurement");

  sleepLoop_a:
    assert property (@(posedge clk) disable iff (!rstN)
      state == ST_MEAS && autoSlp && inactEvt && !ctrlWr |=> state == ST_WAKE)
    else $error("autosleep did not return to wake");

  linkSwap_a:
    assert property (@(posedge clk) disable iff (!rstN)
      linkOn && actEvt && !ctrlWr |=> expectInact ##0 (!actDetEn || !linkOn))
    else $error("linked mode did not switch detector");

endmodule

/* File: sim/aad_host_model.sv */
// Purpose: host side of the register port, configures and services the detector
// Assumes: write is one strobe cycle, read data stands the cycle after re
// Notes: released bus lines show inverted values so stale data never looks valid
`timescale 1ns/10ps
module aad_host_model
  import aad_pkg::*;
(
  input wire logic clk,
  input wire logic [DW-1:0] rdata,
  output aadBusReq_s bus
);
  logic [DW-1:0] bitsKeep;

  initial begin
    bus = '0;
    bitsKeep = '0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: ~bus.wdata, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: bus.wdata, we: 1'b0, re: 1'b0};
    #1 d = rdata;
  endtask

  // all detector settings land while in standby
  task automatic setup(input logic [DW-1:0] bits, input logic [5:0] axes,
                       input logic [TW-1:0] athr, input logic [TW-1:0] ithr,
                       input logic [7:0] at, input logic [15:0] it);
    logic [DW-1:0] d;
    int i;
    bitsKeep = bits;
    wr(REG_CTRL, 16'h0000);
    wr(REG_CTRL, bits);
    wr(REG_AXIS_ENABLE, {10'h000, axes});
    for (i = 0; i < 3; i++) begin
      wr(REG_X_AXIS_MOTION_THRESHOLD + AW'(i), {5'h00, athr});
      wr(REG_X_AXIS_STILL_THRESHOLD + AW'(i), {5'h00, ithr});
    end
    wr(REG_ACT_TIME, {8'h00, at});
    wr(REG_INACT_TIME, it);
    rd(REG_SECONDARY_EVENT_STATUS, d);
  endtask

  // mode change after wake-triggered measurement is the host's job
  task automatic go(input logic [1:0] m);
    wr(REG_CTRL, bitsKeep | {14'h0000, m});
  endtask
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench of the motion event detector
// Assumes: timer periods shrunk to 8/4/16/8 clocks through parameters
// Notes: samples are sent back to back so a run is only broken on purpose
`timescale 1ns/10ps
module tb;
  import aad_pkg::*;
  localparam logic [15:0] FAST = 16'h0004;
  localparam logic [15:0] AREF = 16'h0008;
  localparam logic [15:0] IREF = 16'h0010;
  localparam logic [15:0] LPF = 16'h0020;
  localparam logic [15:0] LINKED = 16'h0040;
  localparam logic [15:0] LOOP = 16'h00c0;
  localparam logic [15:0] ASLP = 16'h0100;
  localparam logic [15:0] AIE = 16'h0200;
  localparam logic [15:0] IIE = 16'h0400;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sampleValid = 1'b0;
  aadAccel_s sample = '0;
  aadBusReq_s bus;
  logic [DW-1:0] rdata;
  logic actIrq;
  logic inactIrq;
  logic awake;
  aadState_e state;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] rv;

  always #2.5 clk = ~clk;

  aad_host_model i_host (.clk(clk), .rdata(rdata), .bus(bus));

  aad_activity_detector #(
    .ACT_SLOW_CYC_P(24'h000008),
    .ACT_FAST_CYC_P(24'h000004),
    .INACT_SLOW_CYC_P(24'h000010),
    .INACT_FAST_CYC_P(24'h000008)
  ) i_dut (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .sampleValid(sampleValid), .sample(sample), .actIrq(actIrq),
    .inactIrq(inactIrq), .awake(awake), .state(state)
  );

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic st(input logic [1:0] mask, input logic [1:0] exp);
    i_host.rd(REG_SECONDARY_EVENT_STATUS, rv);
    chk("event status", {14'h0000, rv[1:0] & mask}, {14'h0000, exp});
  endtask

  task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z,
                     input int n);
    repeat (n) begin
      @(posedge clk);
      sampleValid <= 1'b1;
      sample.axis[0] <= x;
      sample.axis[1] <= y;
      sample.axis[2] <= z;
    end
  endtask

  task automatic idle();
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, unmapped place
    i_host.rd(REG_CTRL, rv);
    chk("ctrl reset", rv, 16'h0000);
    i_host.rd(REG_ACT_TIME, rv);
    chk("act time reset", rv, 16'h0000);
    i_host.rd(4'hb, rv);
    chk("unmapped read", rv, 16'h0000);
    // absolute activity, per-axis thresholds
    i_host.setup(AIE, 6'h07, 11'h064, 11'h7ff, 8'h00, 16'h0000);
    i_host.wr(REG_X_AXIS_MOTION_THRESHOLD + 4'h1, 16'h07ff);
    i_host.go(MODE_MEAS);
    smp(12'hf38, 12'h000, 12'h000, 1);
    idle();
    chk("act irq", {15'h0000, actIrq}, 16'h0001);
    st(2'b01, 2'b01);
    smp(12'h000, 12'h0c8, 12'h000, 1);
    idle();
    st(2'b01, 2'b00);
    smp(12'h000, 12'h000, 12'h0c8, 1);
    idle();
    st(2'b01, 2'b01);
    // activity timer, broken runs restart
    i_host.setup(16'h0000, 6'h01, 11'h064, 11'h7ff, 8'h02, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h0c8, 12'h000, 12'h000, 12);
    smp(12'h00a, 12'h000, 12'h000, 1);
    smp(12'h0c8, 12'h000, 12'h000, 12);
    smp(12'h00a, 12'h000, 12'h000, 1);
    idle();
    st(2'b01, 2'b00);
    smp(12'h0c8, 12'h000, 12'h000, 30);
    idle();
    st(2'b01, 2'b01);
    i_host.setup(FAST, 6'h01, 11'h064, 11'h7ff, 8'h02, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h0c8, 12'h000, 12'h000, 12);
    idle();
    st(2'b01, 2'b01);
    // inactivity, all enabled axes, timer
    i_host.setup(IIE, 6'h18, 11'h7ff, 11'h032, 8'h00, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h00a, 12'h0c8, 12'h000, 1);
    idle();
    st(2'b10, 2'b00);
    smp(12'h00a, 12'hff6, 12'h000, 1);
    idle();
    chk("inact irq", {15'h0000, inactIrq}, 16'h0001);
    st(2'b10, 2'b10);
    i_host.setup(16'h0000, 6'h08, 11'h7ff, 11'h032, 8'h00, 16'h0001);
    i_host.go(MODE_MEAS);
    smp(12'h00a, 12'h000, 12'h000, 8);
    idle();
    st(2'b10, 2'b00);
    smp(12'h00a, 12'h000, 12'h000, 40);
    idle();
    st(2'b10, 2'b10);
    i_host.setup(FAST, 6'h08, 11'h7ff, 11'h032, 8'h00, 16'h0001);
    i_host.go(MODE_MEAS);
    smp(12'h00a, 12'h000, 12'h000, 12);
    idle();
    st(2'b10, 2'b10);
    // referenced comparisons, reference taken on measurement entry
    i_host.setup(AREF | IREF, 6'h09, 11'h064, 11'h032, 8'h00, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h1f4, 12'h000, 12'h000, 1);
    idle();
    i_host.rd(REG_SECONDARY_EVENT_STATUS, rv);
    smp(12'h226, 12'h000, 12'h000, 1);
    idle();
    st(2'b11, 2'b00);
    smp(12'h208, 12'h000, 12'h000, 1);
    idle();
    st(2'b11, 2'b10);
    smp(12'h28a, 12'h000, 12'h000, 1);
    idle();
    st(2'b01, 2'b01);
    // smoothing filter slows the response
    i_host.setup(LPF, 6'h01, 11'h064, 11'h7ff, 8'h00, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    idle();
    st(2'b01, 2'b00);
    smp(12'h0c8, 12'h000, 12'h000, 30);
    idle();
    st(2'b01, 2'b01);
    // wake mode: detection without interrupts, wake-up on activity
    i_host.setup(IIE, 6'h08, 11'h7ff, 11'h032, 8'h00, 16'h0000);
    i_host.go(MODE_WAKE);
    smp(12'h00a, 12'h000, 12'h000, 1);
    idle();
    chk("wake inact irq", {15'h0000, inactIrq}, 16'h0000);
    chk("wake state", {13'h0000, state}, {13'h0000, ST_WAKE});
    st(2'b10, 2'b10);
    i_host.setup(AIE, 6'h01, 11'h064, 11'h7ff, 8'h00, 16'h0000);
    i_host.go(MODE_WAKE);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    idle();
    chk("wake to meas", {13'h0000, state}, {13'h0000, ST_MEAS});
    chk("awake default", {15'h0000, awake}, 16'h0001);
    st(2'b01, 2'b01);
    i_host.setup(AIE, 6'h01, 11'h064, 11'h7ff, 8'h02, 16'h0000);
    i_host.go(MODE_WAKE);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    idle();
    chk("wake to meas", {13'h0000, state}, {13'h0000, ST_MEAS});
    st(2'b01, 2'b00);
    // autosleep loop
    i_host.setup(ASLP, 6'h09, 11'h064, 11'h032, 8'h00, 16'h0000);
    i_host.go(MODE_WAKE);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    idle();
    chk("sleep to meas", {13'h0000, state}, {13'h0000, ST_MEAS});
    smp(12'h00a, 12'h000, 12'h000, 1);
    idle();
    chk("meas to wake", {13'h0000, state}, {13'h0000, ST_WAKE});
    // linked detectors alternate
    i_host.setup(LINKED, 6'h09, 11'h064, 11'h032, 8'h00, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    idle();
    st(2'b11, 2'b01);
    chk("awake linked", {15'h0000, awake}, 16'h0001);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    idle();
    st(2'b11, 2'b00);
    smp(12'h00a, 12'h000, 12'h000, 1);
    idle();
    st(2'b11, 2'b10);
    chk("asleep linked", {15'h0000, awake}, 16'h0000);
    // loop mode: the next detector does not wait for the host
    i_host.setup(LOOP, 6'h09, 11'h064, 11'h032, 8'h00, 16'h0000);
    i_host.go(MODE_MEAS);
    smp(12'h0c8, 12'h000, 12'h000, 1);
    smp(12'h00a, 12'h000, 12'h000, 1);
    idle();
    st(2'b11, 2'b11);
    complete_run();
  end
endmodule
